/* File: design/gate_prot.sv */
// gate command and protection logic of a three-phase inverter driver
//
// Behaviour
// - high input on, both high in phase off
// - over-current trips fault low, switches off
// - over-current recovers after delay, automatically
// - under-voltage trips fault low, switches off
// - under-voltage recovers after fixed minimum delay
// - thermal flag trips fault low, switches off
// - thermal recovers after hysteresis and delay
// - shutdown sense trips fault low, switches off
// - shutdown recovers below release level, delay
// - three trips use configured recovery delay
// - adjustable base delay about one millisecond
// - fixed delay never under twenty microseconds
// - recovery pin low while those trips active
// - under-voltage always uses fixed minimum delay
`timescale 1ns/10ps
`include "gate_prot_cfg.svh"
module gate_prot (
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  input  wire logic  phase_a_high_in_i,
  input  wire logic  phase_b_high_in_i,
  input  wire logic  phase_c_high_in_i,
  input  wire logic  phase_a_low_in_i,
  input  wire logic  phase_b_low_in_i,
  input  wire logic  phase_c_low_in_i,
  input  wire logic  current_sense_in_i,
  input  wire logic  supply_undervoltage_trip_i,
  input  wire logic  thermal_trip_i,
  input  wire logic  overvolt_sense_in_i,
  input  wire logic  recovery_adjust_en_i,
  input  wire logic  wb_cyc_i,
  input  wire logic  wb_stb_i,
  input  wire logic  wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             phase_a_high_o,
  output logic             phase_b_high_o,
  output logic             phase_c_high_o,
  output logic             phase_a_low_o,
  output logic             phase_b_low_o,
  output logic             phase_c_low_o,
  output logic             fault_n_o,
  output logic             recovery_set_pin_o,
  output logic             recovery_set_pin_oe_o
);
  localparam logic [3:0] ADJ_OFS = 4'h0;
  localparam logic [3:0] FIX_OFS = 4'h4;
  localparam logic [3:0] STA_OFS = 4'h8;

  // pins come from outside the clock domain: two-stage synchronisers
  logic [9:0] meta_q;
  logic [9:0] sync_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= {recovery_adjust_en_i, overvolt_sense_in_i, thermal_trip_i,
                 supply_undervoltage_trip_i, current_sense_in_i,
                 phase_c_low_in_i, phase_b_low_in_i, phase_a_low_in_i,
                 phase_c_high_in_i, phase_b_high_in_i};
      sync_q <= meta_q;
    end
  end
  logic a_hi_meta_q;
  logic a_hi_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a_hi_meta_q <= 1'b0;
      a_hi_q      <= 1'b0;
    end else begin
      a_hi_meta_q <= phase_a_high_in_i;
      a_hi_q      <= a_hi_meta_q;
    end
  end

  // programmable delays in clock cycles
  logic [`CNT_W-1:0] adj_delay_q;
  logic [`CNT_W-1:0] fix_delay_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      adj_delay_q <= `CNT_W'(`ADJ_BASE_CYC);
      fix_delay_q <= `CNT_W'(`FIXED_MIN_CYC);
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o) begin
      if (wb_adr_i == ADJ_OFS) begin
        if (wb_sel_i[0]) adj_delay_q[7:0]   <= wb_dat_i[7:0];
        if (wb_sel_i[1]) adj_delay_q[15:8]  <= wb_dat_i[15:8];
        if (wb_sel_i[2]) adj_delay_q[19:16] <= wb_dat_i[19:16];
      end else if (wb_adr_i == FIX_OFS) begin
        // writes below the minimum are ignored, so the floor is never undercut
        if (wb_dat_i[19:0] >= `CNT_W'(`FIXED_MIN_CYC)) begin
          fix_delay_q <= wb_dat_i[19:0];
        end
      end
    end
  end

  logic [`NUM_TRIPS-1:0] cond;
  logic [`NUM_TRIPS-1:0] hold;
  logic [`NUM_TRIPS-1:0] tripped;
  assign cond[`TRIP_OC] = sync_q[5];
  assign cond[`TRIP_UV] = sync_q[6];
  assign cond[`TRIP_TH] = sync_q[7];
  assign cond[`TRIP_SD] = sync_q[8];

  // adjustable delay only for the three non-supply trips
  logic [`CNT_W-1:0] sel_delay;
  assign sel_delay = sync_q[9] ? adj_delay_q : fix_delay_q;

  genvar gi;
  generate
    for (gi = 0; gi < `NUM_TRIPS; gi++) begin : g_ch
      recovery_if rif ();
      assign rif.cond  = cond[gi];
      assign rif.delay = (gi == `TRIP_UV) ? fix_delay_q : sel_delay;
      assign hold[gi]    = rif.hold;
      assign tripped[gi] = rif.tripped;
      recovery_timer u_timer (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ch    (rif.chan)
      );
    end
  endgenerate

  logic block;
  assign block = |hold;

  logic [2:0] hi;
  logic [2:0] lo;
  assign hi = {sync_q[1], sync_q[0], a_hi_q};
  assign lo = {sync_q[4], sync_q[3], sync_q[2]};
  logic [2:0] hi_en;
  logic [2:0] lo_en;
  assign hi_en = block ? 3'h0 : (hi & ~lo);
  assign lo_en = block ? 3'h0 : (lo & ~hi);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_a_high_o <= 1'b0;
      phase_b_high_o <= 1'b0;
      phase_c_high_o <= 1'b0;
      phase_a_low_o  <= 1'b0;
      phase_b_low_o  <= 1'b0;
      phase_c_low_o  <= 1'b0;
    end else begin
      phase_a_high_o <= hi_en[0];
      phase_b_high_o <= hi_en[1];
      phase_c_high_o <= hi_en[2];
      phase_a_low_o  <= lo_en[0];
      phase_b_low_o  <= lo_en[1];
      phase_c_low_o  <= lo_en[2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_n_o             <= 1'b1;
      recovery_set_pin_o    <= 1'b0;
      recovery_set_pin_oe_o <= 1'b0;
    end else begin
      fault_n_o             <= !block;
      recovery_set_pin_o    <= 1'b0;
      // open drain: pulled low only while an over-current, thermal or shutdown trip is still asserted
      recovery_set_pin_oe_o <= tripped[`TRIP_OC] | tripped[`TRIP_TH]
                               | tripped[`TRIP_SD];
    end
  end

  // wishbone classic slave, one wait state, ack drops after one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (wb_adr_i == ADJ_OFS) begin
        wb_dat_o <= {12'h000, adj_delay_q};
      end else if (wb_adr_i == FIX_OFS) begin
        wb_dat_o <= {12'h000, fix_delay_q};
      end else if (wb_adr_i == STA_OFS) begin
        wb_dat_o <= {23'h000000, !block, hold, tripped};
      end else begin
        wb_dat_o <= 32'h00000000;
      end
    end
  end
endmodule

/* File: design/gate_prot_cfg.svh */
// timing constants and reset values for the gate protection logic
`ifndef GATE_PROT_CFG_SVH
`define GATE_PROT_CFG_SVH
`define CLK_HZ             20000000
`define ADJ_BASE_US        1000
`define FIXED_MIN_US       20
`define ADJ_BASE_CYC       ((`ADJ_BASE_US * (`CLK_HZ / 1000000)))
`define FIXED_MIN_CYC      ((`FIXED_MIN_US * (`CLK_HZ / 1000000)))
`define CNT_W              20
`define NUM_TRIPS          4
`define TRIP_OC            0
`define TRIP_UV            1
`define TRIP_TH            2
`define TRIP_SD            3
`endif

/* File: design/gate_prot_pkg.sv */
// types shared by the gate protection logic
package gate_prot_pkg;
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_TRIPPED = 3'b010,
    ST_WAIT    = 3'b100
  } rec_state_t;
endpackage

/* File: design/recovery_if.sv */
// request and status signals between the top and one recovery channel
`timescale 1ns/10ps
interface recovery_if;
  logic        cond;
  logic [19:0] delay;
  logic        hold;
  logic        tripped;
  modport top (output cond, output delay, input hold, input tripped);
  modport chan (input cond, input delay, output hold, output tripped);
endinterface

/* File: design/recovery_timer.sv */
// one trip channel: latches a condition and times its recovery delay
`timescale 1ns/10ps
`include "gate_prot_cfg.svh"
module recovery_timer (
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  recovery_if.chan   ch
);
  gate_prot_pkg::rec_state_t state_q;
  logic [`CNT_W-1:0]         cnt_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= gate_prot_pkg::ST_IDLE;
      cnt_q   <= '0;
    end else begin
      case (state_q)
        gate_prot_pkg::ST_IDLE: begin
          if (ch.cond) begin
            state_q <= gate_prot_pkg::ST_TRIPPED;
          end
        end
        gate_prot_pkg::ST_TRIPPED: begin
          cnt_q <= '0;
          if (!ch.cond) begin
            state_q <= gate_prot_pkg::ST_WAIT;
          end
        end
        gate_prot_pkg::ST_WAIT: begin
          if (ch.cond) begin
            state_q <= gate_prot_pkg::ST_TRIPPED;
          end else if (cnt_q + 20'h00001 >= ch.delay) begin
            state_q <= gate_prot_pkg::ST_IDLE;
          end else begin
            cnt_q <= cnt_q + 20'h00001;
          end
        end
        default: state_q <= gate_prot_pkg::ST_IDLE;
      endcase
    end
  end

  assign ch.hold    = (state_q != gate_prot_pkg::ST_IDLE) || ch.cond;
  assign ch.tripped = (state_q == gate_prot_pkg::ST_TRIPPED) || ch.cond;
endmodule

/* File: dv/pwm_ctrl_model.sv */
// pwm controller model driving the six gate commands
`timescale 1ns/10ps
module pwm_ctrl_model (
  input  wire logic       clk_i,
  input  wire logic [5:0] cmd_i,
  output logic [5:0]      gate_o = 6'h00
);
  // commands change just after an edge, as a real controller's flops would
  always @(posedge clk_i) begin
    gate_o <= cmd_i;
  end
endmodule

/* File: dv/gate_prot_properties.sv */
// concurrent checks on the gate protection ports
`timescale 1ns/10ps
module gate_prot_properties (
  input wire logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_ack_o,
  input wire logic current_sense_in_i, supply_undervoltage_trip_i,
  input wire logic thermal_trip_i, overvolt_sense_in_i,
  input wire logic phase_a_high_in_i, phase_a_low_in_i,
  input wire logic phase_a_high_o, phase_b_high_o, phase_c_high_o,
  input wire logic phase_a_low_o, phase_b_low_o, phase_c_low_o,
  input wire logic fault_n_o, recovery_set_pin_o, recovery_set_pin_oe_o
);
  wire any_flag = current_sense_in_i | supply_undervoltage_trip_i | thermal_trip_i
                  | overvolt_sense_in_i;
  wire any_sw = phase_a_high_o | phase_b_high_o | phase_c_high_o | phase_a_low_o
                | phase_b_low_o | phase_c_low_o;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_off;
    !fault_n_o && !any_sw;
  endsequence
  property p_ack;
    s_req |=> wb_ack_o;
  endproperty
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  property p_shoot;
    !(phase_a_high_o && phase_a_low_o) && !(phase_b_high_o && phase_b_low_o)
    && !(phase_c_high_o && phase_c_low_o);
  endproperty
  // two sync stages plus the output flop
  property p_follow;
    fault_n_o && $past(fault_n_o) && $past(fault_n_o, 2) |-> phase_a_high_o ==
    ($past(phase_a_high_in_i, 3) && !$past(phase_a_low_in_i, 3));
  endproperty
  property p_trip;
    $rose(any_flag) |-> ##[1:3] s_off;
  endproperty
  property p_off;
    !fault_n_o |-> !any_sw;
  endproperty
  property p_oe;
    $rose(current_sense_in_i) |-> ##[1:3] recovery_set_pin_oe_o;
  endproperty
  property p_oe_fault;
    recovery_set_pin_oe_o |-> !fault_n_o && !recovery_set_pin_o;
  endproperty
  property p_release;
    $rose(fault_n_o) |-> !$past(any_flag, 4) && !$past(any_flag, 8);
  endproperty
  a_ack: assert property (p_ack) else $error("bus request not acknowledged");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_shoot: assert property (p_shoot) else $error("both switches of a phase on");
  a_follow: assert property (p_follow) else $error("phase a not following");
  a_trip: assert property (p_trip) else $error("trip not applied");
  a_off: assert property (p_off) else $error("switch on during trip");
  a_oe: assert property (p_oe) else $error("recovery pin not pulled");
  a_oe_fault: assert property (p_oe_fault) else $error("recovery pin wrong");
  a_release: assert property (p_release) else $error("early release");
endmodule

/* File: dv/gate_prot_tb_top.sv */
// self-checking bench for the gate protection logic
`timescale 1ns/10ps
module gate_prot_tb_top;
  logic clk_i, rst_i = 1'b1, recovery_adjust_en_i = 1'b1, wb_req = 1'b0, wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0, flags = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [5:0] cmd = 6'h00;
  logic [5:0] pat [4] = '{6'h07, 6'h38, 6'h3F, 6'h1A};
  int err_total = 0, check_count = 0, n, dly;
  wire phase_a_high_in_i, phase_b_high_in_i, phase_c_high_in_i;
  wire phase_a_low_in_i, phase_b_low_in_i, phase_c_low_in_i;
  wire current_sense_in_i = flags[0], supply_undervoltage_trip_i = flags[1];
  wire thermal_trip_i = flags[2], overvolt_sense_in_i = flags[3];
  wire [31:0] wb_dat_o;
  wire wb_ack_o, phase_a_high_o, phase_b_high_o, phase_c_high_o, phase_a_low_o;
  wire phase_b_low_o, phase_c_low_o, fault_n_o, recovery_set_pin_o, recovery_set_pin_oe_o;
  wire [5:0] sw = {phase_c_low_o, phase_b_low_o, phase_a_low_o,
                   phase_c_high_o, phase_b_high_o, phase_a_high_o};
  pwm_ctrl_model u_pwm (.clk_i(clk_i), .cmd_i(cmd), .gate_o({phase_c_low_in_i,
    phase_b_low_in_i, phase_a_low_in_i, phase_c_high_in_i, phase_b_high_in_i,
    phase_a_high_in_i}));
  gate_prot dut (.*, .wb_cyc_i(wb_req), .wb_stb_i(wb_req), .wb_sel_i(4'hF));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd, exp);
    int k;
    k = 0;
    wb_req <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    if (wb_ack_o !== 1'b1) begin
      err_total++;
      finish_test();
    end
    if (!we) chk("rdata", exp, wb_dat_o);
    wb_req <= 1'b0;
    @(posedge clk_i);
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("sw_rst", 32'h0, sw);
    wb(1'b0, 4'h0, 32'h0, 32'h4E20);
    wb(1'b0, 4'h8, 32'h0, 32'h100);
    wb(1'b0, 4'hC, 32'h0, 32'h0);
    wb(1'b1, 4'h4, 32'h10, 32'h0);
    wb(1'b0, 4'h4, 32'h0, 32'h190);
    wb(1'b1, 4'h0, 32'hA, 32'h0);
    wb(1'b0, 4'h0, 32'h0, 32'hA);
    for (int i = 0; i < 4; i++) begin
      cmd <= pat[i];
      repeat (6) @(posedge clk_i);
      chk("gates", {pat[i][5:3] & ~pat[i][2:0], pat[i][2:0] & ~pat[i][5:3]}, sw);
    end
    cmd <= 6'h07;
    // pass 4 repeats over-current with the fixed delay selected
    for (int i = 0; i < 5; i++) begin
      recovery_adjust_en_i <= (i < 4);
      flags <= 4'h1 << (i % 4);
      repeat (4) @(posedge clk_i);
      chk("fault", 32'h0, fault_n_o);
      chk("sw_off", 32'h0, sw);
      chk("oe", (i % 4) != 1, recovery_set_pin_oe_o);
      flags <= 4'h0;
      repeat (5) @(posedge clk_i);
      chk("early", 32'h0, fault_n_o);
      flags <= 4'h1 << (i % 4);
      repeat (4) @(posedge clk_i);
      flags <= 4'h0;
      n = 0;
      while (fault_n_o !== 1'b1 && n < 1000) begin
        @(posedge clk_i);
        n++;
      end
      if (n >= 1000) begin
        err_total++;
        finish_test();
      end
      dly = (i % 4 == 1 || i == 4) ? 400 : 10;
      chk("delay_lo", 32'h1, n >= dly);
      chk("delay_hi", 32'h1, n <= dly + 8);
      repeat (4) @(posedge clk_i);
      chk("resume", 32'h7, sw);
    end
    finish_test();
  end
endmodule
bind gate_prot gate_prot_properties u_props (.*);
